// ==== src/orws_top.sv ====
/*
  OTP range window select: one 16-entry shared register block that
  mirrors one 16-address OTP range chosen by a load-select register,
  plus a read-only active-range status register.
  Assumes a serial engine (SPI or I2C) on the same clock presents
  one-cycle write and read strobes with an 8-bit address, and that the
  init lock and the error-detection checker sit outside.
  // Operation
  // - Sixteen shared registers show one range
  // - Codes Ah..Fh map A0h..FFh ranges
  // - Status reports currently loaded range code
  // - Status zero while copy is running
  // - Status one after host overwrites window
  // - Window read decodes low nibble only
  // - No mismatch flag beyond status read
  // - After init lock, writes are ignored
  // - Both registers feed error detection
  // - Select RW, status RO on both interfaces
  // - Writes to new region move base, keep data
*/
`timescale 1ns/1ns
`default_nettype none

module orws_top
  import orws_pkg::*;
(
  input  wire logic       I_CLK,
  input  wire logic       I_RESET,
  input  wire logic       I_WR_STB,
  input  wire logic       I_RD_STB,
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_INIT_DONE_LOCK,
  output var  logic [7:0] O_RDATA,
  output var  logic       O_RVALID,
  output var  logic [7:0] O_LOAD_SELECT_REG,
  output var  logic [7:0] O_ACTIVE_STATUS_REG
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  orws_state_type state_r;
  logic [3:0]     load_code_r;
  logic [3:0]     active_code_r;
  logic [3:0]     copy_code_r;
  logic [4:0]     copy_cnt_r;
  logic [3:0]     base_r;
  logic [7:0]     window_r [WINDOW_WORDS];
  logic [6:0]     rom_addr;
  logic [7:0]     rom_data;
  logic           wr_ok;
  logic           wr_sel;
  logic           wr_win;
  logic           win_hit;
  logic           valid_code;
  logic [3:0]     wr_code;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Lock blocks every write here; soft reset bits live elsewhere
  assign wr_ok      = I_WR_STB && !I_INIT_DONE_LOCK;
  assign wr_sel     = wr_ok && (I_ADDR == OFS_LOAD_SELECT);
  assign win_hit    = I_ADDR[7:4] >= WIN_BASE_NIB_LO;
  assign wr_win     = wr_ok && win_hit;
  assign wr_code    = I_WDATA[FLD_CODE_MSB:FLD_CODE_LSB];
  // Only Ah..Fh start a copy; reserved codes are stored, nothing loads
  assign valid_code = wr_code >= CODE_FIRST_OK;

  // ----------------------------------------------------------------
  // OTP read port
  // ----------------------------------------------------------------
  // Range code Ah..Fh selects 16-byte slice (code - Ah) of the array
  assign rom_addr = {3'(copy_code_r - CODE_FIRST_OK), copy_cnt_r[3:0]};

  orws_otp_rom #(
    .DEPTH (96)
  ) u_rom (
    .i_clk  (I_CLK),
    .i_addr (rom_addr),
    .o_data (rom_data)
  );

  // ----------------------------------------------------------------
  // Load-select register
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
      load_code_r <= RST_CODE;
    else if (wr_sel)
      load_code_r <= wr_code;
  end

  // ----------------------------------------------------------------
  // Copy sequencer and active status
  // ----------------------------------------------------------------
  // Copy runs 18 cycles, far inside the host's 1000-cycle wait
  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      state_r       <= ST_IDLE;
      copy_cnt_r    <= 5'h0_0;
      copy_code_r   <= RST_CODE;
      active_code_r <= RST_CODE;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (wr_sel && valid_code)
          begin
            state_r       <= ST_COPY;
            copy_cnt_r    <= 5'h0_0;
            copy_code_r   <= wr_code;
            active_code_r <= CODE_BUSY;
          end
          else if (wr_win)
            active_code_r <= CODE_OVERWRITE;
        end
        ST_COPY:
        begin
          copy_cnt_r <= copy_cnt_r + 5'h0_1;
          if (copy_cnt_r == 5'(LOAD_CYCLES - 1))
          begin
            state_r       <= ST_IDLE;
            active_code_r <= copy_code_r;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shared window and base
  // ----------------------------------------------------------------
  // Host write to another range moves the base but keeps other words
  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
      base_r <= RST_CODE;
    else if (state_r == ST_IDLE && wr_sel && valid_code)
      base_r <= wr_code;
    else if (state_r == ST_IDLE && wr_win)
      base_r <= I_ADDR[7:4];
  end

  // One word per cycle, lagging the address by the ROM latency
  generate
    for (genvar g = 0; g < WINDOW_WORDS; g++)
    begin : g_win
      always_ff @(posedge I_CLK)
      begin
        if (I_RESET)
          window_r[g] <= 8'h00;
        // Data at count n belongs to word n-1; count 16 wraps to word 15
        else if (state_r == ST_COPY && copy_cnt_r >= 5'h0_1
                 && copy_cnt_r[3:0] - 4'h1 == 4'(g)
                 && copy_cnt_r <= 5'(WINDOW_WORDS))
          window_r[g] <= rom_data;
        else if (state_r == ST_IDLE && wr_win && I_ADDR[3:0] == 4'(g))
          window_r[g] <= I_WDATA;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // No check of upper nibble against base; status read is the only check
  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      O_RDATA  <= 8'h00;
      O_RVALID <= 1'b0;
    end
    else
    begin
      O_RVALID <= I_RD_STB;
      if (I_RD_STB)
      begin
        if (I_ADDR == OFS_LOAD_SELECT)
          O_RDATA <= {load_code_r, 4'h0};
        else if (I_ADDR == OFS_ACTIVE_STATUS)
          O_RDATA <= {active_code_r, 4'h0};
        else if (win_hit)
          O_RDATA <= window_r[I_ADDR[3:0]];
        else
          O_RDATA <= 8'h00;
      end
    end
  end

  // Mirrors for the outside array error-detection checker
  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      O_LOAD_SELECT_REG   <= {RST_CODE, 4'h0};
      O_ACTIVE_STATUS_REG <= {RST_CODE, 4'h0};
    end
    else
    begin
      O_LOAD_SELECT_REG   <= {load_code_r, 4'h0};
      O_ACTIVE_STATUS_REG <= {active_code_r, 4'h0};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  AST_BUSY_ON_SELECT: assert property (
    (state_r == ST_IDLE && wr_sel && valid_code) |=> active_code_r == CODE_BUSY)
    else $error("status not busy after select");

  AST_DONE_IN_TIME: assert property (
    (state_r == ST_IDLE && wr_sel && valid_code) |=> ##18 active_code_r == $past(wr_code, 19))
    else $error("copy did not finish on time");

  AST_BUSY_HOLDS: assert property (
    (state_r == ST_COPY && copy_cnt_r < 5'(LOAD_CYCLES - 1)) |=> active_code_r == CODE_BUSY)
    else $error("status left busy early");

  AST_OVERWRITE: assert property (
    (state_r == ST_IDLE && wr_win && !wr_sel) |=> active_code_r == CODE_OVERWRITE)
    else $error("overwrite code missing");

  AST_LOCK: assert property (
    (I_WR_STB && I_INIT_DONE_LOCK) |=> $stable(load_code_r) && $stable(base_r))
    else $error("write took effect under lock");

  AST_NIBBLE: assert property (
    (I_RD_STB && win_hit && I_ADDR != OFS_LOAD_SELECT && !(state_r == ST_IDLE && I_WR_STB))
    |=> O_RDATA == $past(window_r[I_ADDR[3:0]]) && O_RVALID)
    else $error("window read wrong");

  AST_STATUS_READ: assert property (
    (I_RD_STB && I_ADDR == OFS_ACTIVE_STATUS) |=> O_RDATA == {$past(active_code_r), 4'h0})
    else $error("status read wrong");

  AST_RESERVED: assert property (
    (wr_sel && !valid_code && state_r == ST_IDLE) |=> state_r == ST_IDLE)
    else $error("reserved code started copy");

  AST_MIRROR: assert property (
    ##1 O_ACTIVE_STATUS_REG == {$past(active_code_r), 4'h0})
    else $error("mirror stale");

  COV_LOAD: cover property (
    (wr_sel && valid_code) ##18 (I_RD_STB && I_ADDR == OFS_ACTIVE_STATUS));
  COV_OVERWRITE: cover property (wr_win ##1 active_code_r == CODE_OVERWRITE);
  COV_LOCKED: cover property (I_WR_STB && I_INIT_DONE_LOCK);
  COV_ALIAS: cover property (I_RD_STB && win_hit && I_ADDR[7:4] != base_r);

endmodule
`default_nettype wire

// ==== src/orws_pkg.sv ====
/*
  Package for the OTP range window select block: register offsets,
  field positions, range and status codes, and the load timing.
  Assumes a single 20 MHz system clock domain.
*/
package orws_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LOAD_SELECT   = 8'h14;
  localparam logic [7:0] OFS_ACTIVE_STATUS = 8'h15;
  localparam logic [3:0] WIN_BASE_NIB_LO   = 4'hA;  // A0h..FFh window

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int         FLD_CODE_MSB   = 7;
  localparam int         FLD_CODE_LSB   = 4;
  localparam logic [3:0] RST_CODE       = 4'hE;   // Reads back as E0h
  localparam logic [3:0] CODE_BUSY      = 4'h0;
  localparam logic [3:0] CODE_OVERWRITE = 4'h1;
  localparam logic [3:0] CODE_FIRST_OK  = 4'hA;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ     = 20_000_000;
  localparam int HOST_WAIT_NS    = 50_000;
  // Copy is one word per cycle plus two cycles of overhead
  localparam int WINDOW_WORDS    = 16;
  localparam int LOAD_CYCLES     = WINDOW_WORDS + 2;
  localparam int HOST_WAIT_CYC   = (HOST_WAIT_NS / 1000) * (CLK_FREQ_HZ / 1_000_000);

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_COPY = 2'b01
  } orws_state_type;

endpackage

// ==== src/orws_otp_rom.sv ====
/*
  OTP array model seen as a read port: 96 bytes covering A0h..FFh,
  one cycle of read latency. Assumes the caller holds the address.
*/
`timescale 1ns/1ns
`default_nettype none

module orws_otp_rom
  import orws_pkg::*;
#(
  parameter int DEPTH = 96
)
(
  input  wire logic       i_clk,
  input  wire logic [6:0] i_addr,
  output var  logic [7:0] o_data
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] mem [DEPTH];

  // Content stands in for fuses; a fixed pattern keeps reads traceable
  generate
    for (genvar g = 0; g < DEPTH; g++)
    begin : g_fill
      assign mem[g] = 8'(g) ^ 8'h5A;
    end
  endgenerate

  // Registered read port
  always_ff @(posedge i_clk)
  begin
    o_data <= (i_addr < 7'(DEPTH)) ? mem[i_addr] : 8'h00;
  end

endmodule
`default_nettype wire

// ==== tb/orws_host_model.sv ====
/*
  Host side of the register bus: one-cycle write and read strobes.
  Assumes the block takes a strobe on the rising edge of i_clk.
*/
`timescale 1ns/1ns
`default_nettype none

module orws_host_model
  import orws_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rvalid,
  input  wire logic [7:0] i_rdata,
  output var  logic       o_wr_stb,
  output var  logic       o_rd_stb,
  output var  logic [7:0] o_addr,
  output var  logic [7:0] o_wdata
);
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // Idle bus shows inverted values, so a stale address never matches
  initial
  begin
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_addr   = 8'h00;
    o_wdata  = 8'h00;
  end

  // Write: strobe held over one taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_wr_stb = 1'b1;
    o_addr   = a;
    o_wdata  = d;
    @(posedge i_clk);
    #1;
    o_wr_stb = 1'b0;
    o_addr   = ~a;
    o_wdata  = ~d;
  endtask

  // Read: returns the valid flag above the data byte
  task automatic rd(input logic [7:0] a, output logic [8:0] v);
    @(posedge i_clk);
    #1;
    o_rd_stb = 1'b1;
    o_addr   = a;
    @(posedge i_clk);
    #1;
    o_rd_stb = 1'b0;
    o_addr   = ~a;
    v        = {i_rvalid, i_rdata};
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Select a range, peek at status once, then sit out the load time
  task automatic sel(input logic [3:0] code, output logic [8:0] busy);
    wr(OFS_LOAD_SELECT, {code, 4'h0});
    rd(OFS_ACTIVE_STATUS, busy);
    wt(HOST_WAIT_CYC);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
/*
  Self-checking bench for the OTP range window select block.
  Assumes the host model drives all bus inputs; the bench drives lock.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top
  import orws_pkg::*;
;
  logic       clk;
  logic       rst;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       lock;
  logic [7:0] rdata;
  logic       rvalid;
  logic [7:0] lsel;
  logic [7:0] asts;
  int         errors;
  int         n_checks;
  int         seed;
  logic [31:0] r;
  logic [3:0] hi;
  logic [3:0] lo;
  logic [8:0] v;

  orws_top dut_u
  (
    .I_CLK               (clk),
    .I_RESET             (rst),
    .I_WR_STB            (wr),
    .I_RD_STB            (rd),
    .I_ADDR              (addr),
    .I_WDATA             (wdata),
    .I_INIT_DONE_LOCK    (lock),
    .O_RDATA             (rdata),
    .O_RVALID            (rvalid),
    .O_LOAD_SELECT_REG   (lsel),
    .O_ACTIVE_STATUS_REG (asts)
  );

  orws_host_model host_u
  (
    .i_clk    (clk),
    .i_rvalid (rvalid),
    .i_rdata  (rdata),
    .o_wr_stb (wr),
    .o_rd_stb (rd),
    .o_addr   (addr),
    .o_wdata  (wdata)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // Expected OTP byte of a range code and low nibble
  function automatic logic [7:0] exp_otp(input logic [3:0] code, input logic [3:0] l);
    return {code - 4'hA, l} ^ 8'h5A;
  endfunction

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog: the run needs well under half of this
  initial
  begin
    #2_000_000;
    errors++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    errors   = 0;
    n_checks = 0;
    seed     = 24484;
    lock     = 1'b0;
    rst      = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    host_u.rd(OFS_LOAD_SELECT, v);
    chk(v, {1'b1, RST_CODE, 4'h0});
    host_u.rd(OFS_ACTIVE_STATUS, v);
    chk(v, {1'b1, RST_CODE, 4'h0});
    chk({1'b0, asts}, {1'b0, RST_CODE, 4'h0});
    // Select, wait, then read four window words of each range
    for (int c = 10; c < 16; c++)
    begin
      host_u.sel(c[3:0], v);
      chk(v, {1'b1, CODE_BUSY, 4'h0});
      host_u.rd(OFS_ACTIVE_STATUS, v);
      chk(v, {1'b1, c[3:0], 4'h0});
      host_u.rd(OFS_LOAD_SELECT, v);
      chk(v, {1'b1, c[3:0], 4'h0});
      chk({1'b0, lsel}, {1'b0, c[3:0], 4'h0});
      // Upper nibble is random on purpose: only the low nibble counts
      for (int k = 0; k < 4; k++)
      begin
        r  = $random(seed);
        hi = 4'hA + 4'(r[7:4] % 4'd6);
        lo = (k == 0) ? 4'hF : r[3:0];
        host_u.rd({hi, lo}, v);
        chk(v, {1'b1, exp_otp(c[3:0], lo)});
      end
    end
    // Reserved code is kept but loads nothing
    host_u.wr(OFS_LOAD_SELECT, 8'h35);
    host_u.wt(HOST_WAIT_CYC);
    host_u.rd(OFS_LOAD_SELECT, v);
    chk(v, 9'h130);
    host_u.rd(OFS_ACTIVE_STATUS, v);
    chk(v, 9'h1F0);
    host_u.wr(OFS_ACTIVE_STATUS, 8'hA0);
    host_u.rd(OFS_ACTIVE_STATUS, v);
    chk(v, 9'h1F0);
    // Host overwrite of one word, the rest stays
    r = $random(seed);
    host_u.wr(8'hC5, r[7:0]);
    host_u.rd(OFS_ACTIVE_STATUS, v);
    chk(v, {1'b1, CODE_OVERWRITE, 4'h0});
    host_u.rd(8'hA5, v);
    chk(v, {1'b1, r[7:0]});
    host_u.rd(8'hE6, v);
    chk(v, {1'b1, exp_otp(4'hF, 4'h6)});
    host_u.rd(8'h20, v);
    chk(v, 9'h100);
    // Lock freezes everything written from here on
    lock = 1'b1;
    host_u.wr(OFS_LOAD_SELECT, 8'hA0);
    host_u.wr(8'hA5, ~r[7:0]);
    host_u.wt(LOAD_CYCLES + 2);
    host_u.rd(OFS_LOAD_SELECT, v);
    chk(v, 9'h130);
    host_u.rd(OFS_ACTIVE_STATUS, v);
    chk(v, 9'h110);
    host_u.rd(8'hD5, v);
    chk(v, {1'b1, r[7:0]});
    conclude();
  end
endmodule
`default_nettype wire
